// *** verilog/protection_mode_pkg.sv ***
// constants for the protection and maintenance mode register block
// assumes an apb master at 200 mhz and a single reset domain
// Operation
// - writing one clears history, command returns zero
// - bit0 under v/f lowers carrier, no trip
// - bit1 set: input phase loss trips
// - bit2 set: output phase loss trips running
// - bit3 selects user capacitor life threshold
// - bit4 discharge judgment; on-time judgment always runs
// - bit5 zero: fan lock alarms and coasts
// - fan lock always drives overheat, life outputs
// - commanded fan stop is normal; start reruns fan
// - bit6 set: braking transistor error trips
// - bit7 selects higher enclosure class
// - mode word is plain 8-bit binary value
// - mode word resets to 0x53
package protection_mode_pkg;
   // -----------------------------------------
   // register offsets (byte addresses)
   // -----------------------------------------
   localparam logic [7:0] OFF_ALARM_CLEAR = 8'h00;
   localparam logic [7:0] OFF_MODE_SELECT = 8'h04;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_STATE = 8'h10;
   localparam logic [7:0] OFF_CONTROL = 8'h14;
   // -----------------------------------------
   // mode word fields and reset
   // -----------------------------------------
   localparam int MODE_W = 8;
   localparam logic [7:0] MODE_RESET = 8'h53;
   localparam int BIT_CARRIER = 0;
   localparam int BIT_IN_PHASE = 1;
   localparam int BIT_OUT_PHASE = 2;
   localparam int BIT_CAP_THRESH = 3;
   localparam int BIT_CAP_JUDGE = 4;
   localparam int BIT_FAN_CONT = 5;
   localparam int BIT_BRAKE = 6;
   localparam int BIT_ENCLOSURE = 7;
   // -----------------------------------------
   // control register
   // -----------------------------------------
   localparam int CTL_VF = 0;
   localparam int CTL_FAN_ONOFF = 1;
   localparam int CTL_ALARM_RESET = 2;
   localparam logic [1:0] CTL_RESET = 2'h1;
   // -----------------------------------------
   // interrupt / event bits
   // -----------------------------------------
   localparam int EV_W = 7;
   localparam int EV_CLEARED = 0;
   localparam int EV_IN_PHASE = 1;
   localparam int EV_OUT_PHASE = 2;
   localparam int EV_FAN = 3;
   localparam int EV_BRAKE = 4;
   localparam int EV_CARRIER = 5;
   localparam int EV_OVERHEAT = 6;
   localparam int SYNC_STAGES = 2;
endpackage

// *** verilog/pin_sync.sv ***
// two-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// *** verilog/fan_lock_guard.sv ***
// fan lock qualification and fan alarm latch
// assumes synchronised lock input and same-clock controls
`timescale 1ns/1ps
module fan_lock_guard (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic lock_det,
   input wire logic fan_commanded_off,
   input wire logic continue_on_lock,
   input wire logic alarm_reset,
   output logic lock_seen,
   output logic fan_alarm
);
   logic lock_valid;
   // a fan stopped on purpose cannot be judged locked
   assign lock_valid = lock_det && !fan_commanded_off;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_seen <= 1'b0;
      end else begin
         lock_seen <= lock_valid;
      end
   end
   // set wins over reset so a persisting lock is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_alarm <= 1'b0;
      end else if (lock_valid && !continue_on_lock) begin
         fan_alarm <= 1'b1;
      end else if (alarm_reset) begin
         fan_alarm <= 1'b0;
      end
   end
endmodule

// *** verilog/protection_mode_config.sv ***
// apb register block for protection mode selection and alarm gating
// assumes detector levels arrive asynchronously from analog circuits
`timescale 1ns/1ps
module protection_mode_config (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic heat_overload_det,
   input wire logic input_phase_loss_det,
   input wire logic output_phase_loss_det,
   input wire logic fan_lock_det,
   input wire logic brake_transistor_err_det,
   input wire logic motor_running,
   output logic alarm_history_clear_pulse,
   output logic carrier_lower,
   output logic stop_request,
   output logic coast_stop,
   output logic overheat_output,
   output logic life_warning,
   output logic fan_run_cmd,
   output logic cap_threshold_user,
   output logic cap_discharge_judge_en,
   output logic cap_ontime_judge_en,
   output logic enclosure_high_class,
   output logic irq
);
   // ------------------------------------------------------------
   // pin synchronisation and fan guard
   // ------------------------------------------------------------
   logic [5:0] raw_pins;
   logic [5:0] pins;
   logic heat_s, inph_s, outph_s, fan_s, brake_s, run_s;
   logic lock_seen, fan_alarm;
   logic [7:0] mode;
   logic [1:0] ctl;
   logic alarm_reset;

   assign raw_pins = {motor_running, brake_transistor_err_det, fan_lock_det,
                      output_phase_loss_det, input_phase_loss_det, heat_overload_det};
   pin_sync #(.W(6)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(raw_pins),
      .q(pins)
   );
   assign {run_s, brake_s, fan_s, outph_s, inph_s, heat_s} = pins;

   fan_lock_guard u_fan (
      .pclk(pclk),
      .presetn(presetn),
      .lock_det(fan_s),
      .fan_commanded_off(!fan_run_cmd),
      .continue_on_lock(mode[protection_mode_pkg::BIT_FAN_CONT]),
      .alarm_reset(alarm_reset),
      .lock_seen(lock_seen),
      .fan_alarm(fan_alarm)
   );

   // ------------------------------------------------------------
   // apb slave, one wait state so read data comes from flops
   // ------------------------------------------------------------
   logic access, wr_en, rd_en, mapped;
   logic [31:0] next_prdata;
   logic [6:0] irq_status, irq_mask, events;
   logic clear_cmd;
   logic in_alarm, out_alarm, brake_alarm, heat_trip;

   assign access = psel && penable && pready;
   assign wr_en = access && pwrite;
   assign rd_en = psel && penable && !pready && !pwrite;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == protection_mode_pkg::OFF_ALARM_CLEAR) ||
                  (a == protection_mode_pkg::OFF_MODE_SELECT) ||
                  (a == protection_mode_pkg::OFF_IRQ_STATUS) ||
                  (a == protection_mode_pkg::OFF_IRQ_MASK) ||
                  (a == protection_mode_pkg::OFF_STATE) ||
                  (a == protection_mode_pkg::OFF_CONTROL);
   endfunction
   assign mapped = is_mapped(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end
   assign pslverr = pready && !mapped;

   always_comb begin
      next_prdata = 32'h0;
      unique case (paddr)
         protection_mode_pkg::OFF_ALARM_CLEAR: next_prdata = {31'h0, clear_cmd};
         protection_mode_pkg::OFF_MODE_SELECT: next_prdata = {24'h0, mode};
         protection_mode_pkg::OFF_IRQ_STATUS: next_prdata = {25'h0, irq_status};
         protection_mode_pkg::OFF_IRQ_MASK: next_prdata = {25'h0, irq_mask};
         protection_mode_pkg::OFF_STATE: next_prdata = {24'h0, lock_seen, fan_run_cmd,
            carrier_lower, heat_trip, brake_alarm, fan_alarm, out_alarm, in_alarm};
         protection_mode_pkg::OFF_CONTROL: next_prdata = {30'h0, ctl};
         default: next_prdata = 32'h0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         prdata <= next_prdata;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= protection_mode_pkg::MODE_RESET;
      end else if (wr_en && paddr == protection_mode_pkg::OFF_MODE_SELECT) begin
         mode <= pwdata[7:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= protection_mode_pkg::CTL_RESET;
      end else if (wr_en && paddr == protection_mode_pkg::OFF_CONTROL) begin
         ctl <= pwdata[1:0];
      end
   end
   // alarm reset is a write-only strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_reset <= 1'b0;
      end else begin
         alarm_reset <= wr_en && paddr == protection_mode_pkg::OFF_CONTROL &&
                        pwdata[protection_mode_pkg::CTL_ALARM_RESET];
      end
   end
   // confirmation keying is left to the operator side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_cmd <= 1'b0;
      end else begin
         clear_cmd <= wr_en && paddr == protection_mode_pkg::OFF_ALARM_CLEAR && pwdata[0];
      end
   end
   assign alarm_history_clear_pulse = clear_cmd;

   // ------------------------------------------------------------
   // protection gating
   // ------------------------------------------------------------
   logic lower_now;
   assign lower_now = mode[protection_mode_pkg::BIT_CARRIER] && ctl[protection_mode_pkg::CTL_VF];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_lower <= 1'b0;
      end else begin
         carrier_lower <= heat_s && lower_now;
      end
   end
   // each alarm latches until an alarm reset; a live cause wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_alarm <= 1'b0;
         out_alarm <= 1'b0;
         brake_alarm <= 1'b0;
         heat_trip <= 1'b0;
      end else begin
         in_alarm <= (inph_s && mode[protection_mode_pkg::BIT_IN_PHASE]) ||
                     (in_alarm && !alarm_reset);
         out_alarm <= (outph_s && run_s && mode[protection_mode_pkg::BIT_OUT_PHASE]) ||
                      (out_alarm && !alarm_reset);
         brake_alarm <= (brake_s && mode[protection_mode_pkg::BIT_BRAKE]) ||
                        (brake_alarm && !alarm_reset);
         heat_trip <= (heat_s && !lower_now) || (heat_trip && !alarm_reset);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_request <= 1'b0;
         coast_stop <= 1'b0;
         overheat_output <= 1'b0;
         life_warning <= 1'b0;
      end else begin
         stop_request <= in_alarm || out_alarm || brake_alarm || heat_trip || fan_alarm;
         coast_stop <= fan_alarm;
         overheat_output <= lock_seen || heat_trip;
         life_warning <= lock_seen;
      end
   end
   // with on/off control the fan only runs while the motor runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_run_cmd <= 1'b1;
      end else begin
         fan_run_cmd <= !ctl[protection_mode_pkg::CTL_FAN_ONOFF] || run_s;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_threshold_user <= 1'b0;
         cap_discharge_judge_en <= 1'b0;
         cap_ontime_judge_en <= 1'b0;
         enclosure_high_class <= 1'b0;
      end else begin
         cap_threshold_user <= mode[protection_mode_pkg::BIT_CAP_THRESH];
         cap_discharge_judge_en <= mode[protection_mode_pkg::BIT_CAP_JUDGE];
         cap_ontime_judge_en <= 1'b1;
         enclosure_high_class <= mode[protection_mode_pkg::BIT_ENCLOSURE];
      end
   end

   // ------------------------------------------------------------
   // interrupts: sticky, write one to clear, set wins
   // ------------------------------------------------------------
   assign events = {heat_trip, carrier_lower, brake_alarm, fan_alarm,
                    out_alarm, in_alarm, clear_cmd};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 7'h0;
      end else if (wr_en && paddr == protection_mode_pkg::OFF_IRQ_STATUS) begin
         irq_status <= (irq_status & ~pwdata[6:0]) | events;
      end else begin
         irq_status <= irq_status | events;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= 7'h0;
      end else if (wr_en && paddr == protection_mode_pkg::OFF_IRQ_MASK) begin
         irq_mask <= pwdata[6:0];
      end
   end
   assign irq = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_clear_pulse: assert property (
      (wr_en && paddr == protection_mode_pkg::OFF_ALARM_CLEAR && pwdata[0])
      |=> alarm_history_clear_pulse ##1 !alarm_history_clear_pulse)
      else $error("clear pulse not one cycle");
   chk_clear_zero: assert property (
      alarm_history_clear_pulse |=> !clear_cmd)
      else $error("clear command did not return to zero");
   chk_clear_nowrite: assert property (
      (wr_en && paddr == protection_mode_pkg::OFF_ALARM_CLEAR && !pwdata[0])
      |=> !alarm_history_clear_pulse)
      else $error("writing zero cleared history");
   chk_carrier_gate: assert property (
      carrier_lower |-> $past(lower_now))
      else $error("carrier lowered without mode");
   chk_in_phase: assert property (
      (inph_s && mode[protection_mode_pkg::BIT_IN_PHASE]) |=> ##1 stop_request)
      else $error("input phase loss did not stop");
   chk_out_phase_off: assert property (
      (!out_alarm && !mode[protection_mode_pkg::BIT_OUT_PHASE]) |=> !out_alarm)
      else $error("output phase alarm while disabled");
   chk_brake_off: assert property (
      (!brake_alarm && !mode[protection_mode_pkg::BIT_BRAKE]) |=> !brake_alarm)
      else $error("brake alarm while disabled");
   chk_fan_outputs: assert property (
      lock_seen |=> overheat_output && life_warning)
      else $error("fan lock did not raise warnings");
   chk_fan_coast: assert property (
      fan_alarm |=> coast_stop)
      else $error("fan alarm did not coast");
   chk_mode_read: assert property (
      (rd_en && paddr == protection_mode_pkg::OFF_MODE_SELECT) |=> prdata == {24'h0, $past(mode)})
      else $error("mode readback mismatch");
   chk_ontime: assert property (
      $rose(presetn) ##1 1'b1 |-> ##1 cap_ontime_judge_en)
      else $error("on-time judgment stopped");
   chk_irq_level: assert property (
      (irq && !(wr_en && (paddr == protection_mode_pkg::OFF_IRQ_STATUS ||
         paddr == protection_mode_pkg::OFF_IRQ_MASK))) |=> irq)
      else $error("interrupt level dropped without a write");
   chk_irq_sticky: assert property (
      !(wr_en && paddr == protection_mode_pkg::OFF_IRQ_STATUS)
      |=> (irq_status & $past(irq_status)) == $past(irq_status))
      else $error("status bit lost without a clear");
   chk_in_phase_off: assert property (
      (!in_alarm && !mode[protection_mode_pkg::BIT_IN_PHASE]) |=> !in_alarm)
      else $error("input phase alarm while disabled");
   chk_carrier_trip: assert property (
      (heat_s && lower_now && !heat_trip) |=> carrier_lower && !heat_trip)
      else $error("overheat tripped instead of lowering carrier");
   chk_brake_trip: assert property (
      (brake_s && mode[protection_mode_pkg::BIT_BRAKE]) |=> brake_alarm)
      else $error("brake error did not raise alarm");
   chk_fan_cmd_off: assert property (
      !fan_run_cmd |=> !lock_seen)
      else $error("lock judged while fan stopped by command");

   cov_clear: cover property (alarm_history_clear_pulse);
   cov_carrier: cover property (carrier_lower && !heat_trip);
   cov_fan_cont: cover property (lock_seen && !fan_alarm);
   cov_irq: cover property (irq ##1 !irq);
endmodule

// *** test/host_apb_model.sv ***
// apb master standing in for the keypad or host software
// assumes one clock; requests launch just after rising edges
`timescale 1ns/1ps
module host_apb_model (
   input wire logic pclk,
   input wire logic presetn,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ------------------------------
   // bus cycle
   // ------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
         output logic [31:0] rdata, output logic err);
      while (presetn !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here: only the bench watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show the inverse so stale values are never trusted
      paddr <= ~addr;
      pwdata <= ~wdata;
   endtask

   // ------------------------------
   // operator actions
   // ------------------------------
   // no two-key confirmation, no clear goes out
   task automatic clear_history(input logic confirmed);
      logic [31:0] r;
      logic e;
      if (confirmed) xfer(1'b1, protection_mode_pkg::OFF_ALARM_CLEAR, 32'h1, r, e);
   endtask

   // mode word sent as plain binary, bit n weighs two to the n
   task automatic set_mode(input logic [7:0] m);
      logic [31:0] r;
      logic e;
      xfer(1'b1, protection_mode_pkg::OFF_MODE_SELECT, {24'h0, m}, r, e);
   endtask
endmodule

// *** test/tb_protection_mode_config.sv ***
// self-checking bench for the protection mode register block
// assumes the apb host model and the package constants
`timescale 1ns/1ps
module tb_protection_mode_config;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, running, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [4:0] det;
   logic clr_pulse, carrier_lower, stop_request, coast_stop, overheat_output, life_warning;
   logic fan_run_cmd, cap_thr, cap_dis, cap_on, encl, ev;
   int n_errors, tests_run;
   // det order: brake, fan, out phase, in phase, heat
   // expected: stop, coast, overheat, life, carrier
   localparam logic [7:0] c_mode [10] = '{8'h53, 8'h51, 8'h57, 8'h53, 8'h53, 8'h13, 8'h53,
      8'h52, 8'h53, 8'h73};
   localparam logic [4:0] c_det [10] = '{5'h02, 5'h02, 5'h04, 5'h04, 5'h10, 5'h10, 5'h01,
      5'h01, 5'h08, 5'h08};
   localparam logic [4:0] c_exp [10] = '{5'h10, 5'h00, 5'h10, 5'h00, 5'h10, 5'h00, 5'h01,
      5'h14, 5'h1e, 5'h06};

   protection_mode_config protection_mode_config_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .heat_overload_det(det[0]),
      .input_phase_loss_det(det[1]), .output_phase_loss_det(det[2]), .fan_lock_det(det[3]),
      .brake_transistor_err_det(det[4]), .motor_running(running),
      .alarm_history_clear_pulse(clr_pulse), .carrier_lower(carrier_lower),
      .stop_request(stop_request), .coast_stop(coast_stop), .overheat_output(overheat_output),
      .life_warning(life_warning), .fan_run_cmd(fan_run_cmd), .cap_threshold_user(cap_thr),
      .cap_discharge_judge_en(cap_dis), .cap_ontime_judge_en(cap_on),
      .enclosure_high_class(encl), .irq(irq));
   host_apb_model host_apb_model_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ------------------------------
   // helpers
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_apb_model_i.xfer(1'b1, a, d, rv, ev);
   endtask

   task automatic rd(input logic [7:0] a);
      host_apb_model_i.xfer(1'b0, a, 32'h0, rv, ev);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic after_reset();
      #1 check({28'h0, fan_run_cmd, cap_dis, encl, stop_request}, 32'hc);
      rd(protection_mode_pkg::OFF_MODE_SELECT);
      check(rv, 32'h53);
      rd(8'h20);
      check({31'h0, ev}, 32'h1);
      check(rv, 32'h0);
   endtask

   task automatic clear_and_irq();
      int pulses;
      pulses = 0;
      host_apb_model_i.clear_history(1'b0);
      wr(protection_mode_pkg::OFF_ALARM_CLEAR, 32'h0);
      repeat (6) begin
         @(posedge pclk);
         pulses += clr_pulse;
      end
      check(32'(pulses), 32'h0);
      host_apb_model_i.clear_history(1'b1);
      repeat (6) begin
         @(posedge pclk);
         pulses += clr_pulse;
      end
      check(32'(pulses), 32'h1);
      rd(protection_mode_pkg::OFF_ALARM_CLEAR);
      check(rv, 32'h0);
      rd(protection_mode_pkg::OFF_IRQ_STATUS);
      check(rv, 32'h1);
      #1 check({31'h0, irq}, 32'h0);
      wr(protection_mode_pkg::OFF_IRQ_MASK, 32'h1);
      @(posedge pclk);
      #1 check({31'h0, irq}, 32'h1);
      wr(protection_mode_pkg::OFF_IRQ_STATUS, 32'h1);
      @(posedge pclk);
      #1 check({31'h0, irq}, 32'h0);
      wr(protection_mode_pkg::OFF_IRQ_MASK, 32'h0);
   endtask

   task automatic mode_fields();
      wr(protection_mode_pkg::OFF_MODE_SELECT, 32'ha5);
      repeat (2) @(posedge pclk);
      #1 check({28'h0, cap_thr, cap_dis, cap_on, encl}, 32'h3);
      rd(protection_mode_pkg::OFF_MODE_SELECT);
      check(rv, 32'ha5);
      wr(protection_mode_pkg::OFF_MODE_SELECT, 32'hffffff18);
      repeat (2) @(posedge pclk);
      #1 check({28'h0, cap_thr, cap_dis, cap_on, encl}, 32'he);
      rd(protection_mode_pkg::OFF_MODE_SELECT);
      check(rv, 32'h18);
   endtask

   task automatic alarm_case(input int k);
      host_apb_model_i.set_mode(c_mode[k]);
      det <= c_det[k];
      repeat (10) @(posedge pclk);
      #1 check({27'h0, stop_request, coast_stop, overheat_output, life_warning, carrier_lower},
         {27'h0, c_exp[k]});
      @(posedge pclk);
      det <= 5'h0;
      repeat (4) @(posedge pclk);
      wr(protection_mode_pkg::OFF_CONTROL, 32'h5);
      repeat (6) @(posedge pclk);
      #1 check({31'h0, stop_request}, 32'h0);
   endtask

   // fan stopped by command hides the lock until a start runs it again
   task automatic fan_onoff();
      host_apb_model_i.set_mode(8'h53);
      wr(protection_mode_pkg::OFF_CONTROL, 32'h3);
      running <= 1'b0;
      // fan command lags the run pin; stop the fan before the lock shows
      repeat (5) @(posedge pclk);
      det <= 5'h08;
      repeat (10) @(posedge pclk);
      #1 check({29'h0, fan_run_cmd, overheat_output, coast_stop}, 32'h0);
      @(posedge pclk);
      running <= 1'b1;
      repeat (10) @(posedge pclk);
      #1 check({29'h0, fan_run_cmd, overheat_output, coast_stop}, 32'h7);
      @(posedge pclk);
      det <= 5'h0;
      wr(protection_mode_pkg::OFF_CONTROL, 32'h5);
   endtask

   // ------------------------------
   // clock, reset, sequence
   // ------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      conclude();
   end

   initial begin
      n_errors = 0;
      tests_run = 0;
      presetn = 1'b0;
      det = 5'h0;
      running = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      after_reset();
      clear_and_irq();
      mode_fields();
      for (int k = 0; k < 10; k++) begin
         alarm_case(k);
      end
      fan_onoff();
      conclude();
   end
endmodule
